//--- dsol_defs.vh
`ifndef DSOL_DEFS_VH
`define DSOL_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSOL_OFS_MAX_FREQ 6'h00
`define DSOL_OFS_START_FREQ 6'h04
`define DSOL_OFS_STD_SET_FREQ 6'h08
`define DSOL_OFS_ACCEL_ON_A 6'h0c
`define DSOL_OFS_DECEL_OFF_A 6'h10
`define DSOL_OFS_ACCEL_ON_B 6'h14
`define DSOL_OFS_DECEL_OFF_B 6'h18
`define DSOL_OFS_FUNC_SEL 6'h1c
`define DSOL_OFS_STATUS 6'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSOL_RST_FREQ 16'h0000
`define DSOL_RST_FUNC_SEL 24'h000100
`define DSOL_RST_WAIT 1'b1

// ----------------------------------------
// Output function codes
// ----------------------------------------
`define DSOL_CODE_RUN 8'h00
`define DSOL_CODE_CONST_SPEED 8'h01
`define DSOL_CODE_OVER_A 8'h02
`define DSOL_CODE_SET_A 8'h06
`define DSOL_CODE_OVER_B 8'h24
`define DSOL_CODE_SET_B 8'h25

// ----------------------------------------
// Hysteresis margins, percent of maximum frequency
// ----------------------------------------
`define DSOL_PCT_ON 8'd1
`define DSOL_PCT_OFF 8'd2
`define DSOL_PCT_DIV 8'd100

// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define DSOL_ST_RUN 0
`define DSOL_ST_CONST 1
`define DSOL_ST_OVER_A 2
`define DSOL_ST_SET_A 3
`define DSOL_ST_OVER_B 4
`define DSOL_ST_SET_B 5
`define DSOL_ST_TERM_LSB 8

`endif

//--- dsol_band.v
`timescale 1ns/1ps
`default_nettype none

// Hysteresis band flag: set inside the turn-on band, cleared outside the
// turn-off band, held in between, forced clear while disabled.
module dsol_band #(
   parameter FW = 16
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_en,
   input wire [FW-1:0] i_freq,
   input wire [FW-1:0] i_on_lo,
   input wire [FW-1:0] i_on_hi,
   input wire [FW-1:0] i_off_lo,
   input wire [FW-1:0] i_off_hi,
   output wire o_flag
);

   reg flag_ff;
   reg nxt_flag;

   // ----------------------------------------
   // Band decision
   // ----------------------------------------
   // Turn-on band wins over turn-off band when both hold
   always @* begin
      nxt_flag = flag_ff;
      if (!i_en) begin
         nxt_flag = 1'b0;
      end else if (i_freq >= i_on_lo && i_freq <= i_on_hi) begin
         nxt_flag = 1'b1;
      end else if (i_freq < i_off_lo || i_freq > i_off_hi) begin
         nxt_flag = 1'b0;
      end
   end

   // Flag register
   always @(posedge i_clk) begin
      if (i_rst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign o_flag = flag_ff;

endmodule // dsol_band

`default_nettype wire

//--- dsol_top.v
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsol_defs.vh"

module dsol_top #(
   parameter FW = 16,
   parameter NTERM = 3
) (
   input wire I_CORE_CLK,
   input wire I_SYS_RST,
   input wire [5:0] I_AVS_ADDRESS,
   input wire I_AVS_READ,
   input wire I_AVS_WRITE,
   input wire [31:0] I_AVS_WRITEDATA,
   input wire [3:0] I_AVS_BYTEENABLE,
   output wire [31:0] O_AVS_READDATA,
   output wire O_AVS_WAITREQUEST,
   input wire I_RUN_MODE,
   input wire I_RAMP_ACCEL,
   input wire I_RAMP_DECEL,
   input wire [FW-1:0] I_OUT_FREQ,
   output wire [NTERM-1:0] O_TERM_OUT_N,
   output wire [NTERM-1:0] O_TERM_OE
);

   localparam [FW-1:0] FULL = {FW{1'b1}};
   localparam [FW-1:0] ZERO = {FW{1'b0}};

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Saturating subtraction, floor at zero
   function [FW-1:0] sat_sub;
      input [FW-1:0] a;
      input [FW-1:0] b;
      begin
         sat_sub = (a > b) ? (a - b) : ZERO;
      end
   endfunction

   // Saturating addition, ceiling at full scale
   function [FW-1:0] sat_add;
      input [FW-1:0] a;
      input [FW-1:0] b;
      reg [FW:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         sat_add = s[FW] ? FULL : s[FW-1:0];
      end
   endfunction

   // Percentage of a frequency value
   function [FW-1:0] pct;
      input [FW-1:0] f;
      input [7:0] p;
      reg [FW+7:0] prod;
      begin
         prod = {8'h00, f} * {{FW{1'b0}}, p};
         prod = prod / {{FW{1'b0}}, `DSOL_PCT_DIV}; // Divide the full product, never a truncated one
         pct = (prod > {8'h00, FULL}) ? FULL : prod[FW-1:0];
      end
   endfunction

   // Byte-enable merge of a write into a stored word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               merge[k*8 +: 8] = wd[k*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   reg [FW-1:0] max_freq_ff;
   reg [FW-1:0] start_freq_ff;
   reg [FW-1:0] standard_set_frequency_ff;
   reg [FW-1:0] accel_on_threshold_a_ff;
   reg [FW-1:0] decel_off_threshold_a_ff;
   reg [FW-1:0] accel_on_threshold_b_ff;
   reg [FW-1:0] decel_off_threshold_b_ff;
   reg [8*NTERM-1:0] func_sel_ff;
   reg [31:0] readdata_ff;
   reg waitrequest_ff;
   reg [31:0] nxt_readdata;
   reg [31:0] status_word;
   wire req;
   wire wr_go;
   wire [5:0] word_adr;
   wire [31:0] wr_word;

   // Addressed word with the enabled write lanes merged in
   assign wr_word = merge(nxt_readdata, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
   assign req = I_AVS_READ | I_AVS_WRITE;
   assign wr_go = I_AVS_WRITE & ~waitrequest_ff;
   assign word_adr = {I_AVS_ADDRESS[5:2], 2'b00};

   // Waitrequest drops for one cycle, the cycle after a request is seen
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         waitrequest_ff <= `DSOL_RST_WAIT;
      end else begin
         waitrequest_ff <= ~(req & waitrequest_ff);
      end
   end

   // Register writes take effect on the edge where waitrequest is low
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         max_freq_ff <= `DSOL_RST_FREQ;
         start_freq_ff <= `DSOL_RST_FREQ;
         standard_set_frequency_ff <= `DSOL_RST_FREQ;
         accel_on_threshold_a_ff <= `DSOL_RST_FREQ;
         decel_off_threshold_a_ff <= `DSOL_RST_FREQ;
         accel_on_threshold_b_ff <= `DSOL_RST_FREQ;
         decel_off_threshold_b_ff <= `DSOL_RST_FREQ;
         func_sel_ff <= `DSOL_RST_FUNC_SEL;
      end else if (wr_go) begin
         case (word_adr)
            `DSOL_OFS_MAX_FREQ: begin
               max_freq_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_START_FREQ: begin
               start_freq_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_STD_SET_FREQ: begin
               standard_set_frequency_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_ACCEL_ON_A: begin
               accel_on_threshold_a_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_DECEL_OFF_A: begin
               decel_off_threshold_a_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_ACCEL_ON_B: begin
               accel_on_threshold_b_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_DECEL_OFF_B: begin
               decel_off_threshold_b_ff <= wr_word[FW-1:0];
            end
            `DSOL_OFS_FUNC_SEL: begin
               func_sel_ff <= wr_word[8*NTERM-1:0];
            end
            default: begin
               func_sel_ff <= func_sel_ff; // Unmapped or read-only: ignored
            end
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero
   always @* begin
      nxt_readdata = 32'h0000_0000;
      case (word_adr)
         `DSOL_OFS_MAX_FREQ: nxt_readdata = {16'h0000, max_freq_ff};
         `DSOL_OFS_START_FREQ: nxt_readdata = {16'h0000, start_freq_ff};
         `DSOL_OFS_STD_SET_FREQ: nxt_readdata = {16'h0000, standard_set_frequency_ff};
         `DSOL_OFS_ACCEL_ON_A: nxt_readdata = {16'h0000, accel_on_threshold_a_ff};
         `DSOL_OFS_DECEL_OFF_A: nxt_readdata = {16'h0000, decel_off_threshold_a_ff};
         `DSOL_OFS_ACCEL_ON_B: nxt_readdata = {16'h0000, accel_on_threshold_b_ff};
         `DSOL_OFS_DECEL_OFF_B: nxt_readdata = {16'h0000, decel_off_threshold_b_ff};
         `DSOL_OFS_FUNC_SEL: nxt_readdata = {{(32-8*NTERM){1'b0}}, func_sel_ff};
         `DSOL_OFS_STATUS: nxt_readdata = status_word;
         default: nxt_readdata = 32'h0000_0000;
      endcase
   end

   // Read data captured as waitrequest drops and held while it is low
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         readdata_ff <= 32'h0000_0000;
      end else if (I_AVS_READ & waitrequest_ff) begin
         readdata_ff <= nxt_readdata;
      end
   end

   assign O_AVS_READDATA = readdata_ff;
   assign O_AVS_WAITREQUEST = waitrequest_ff;

   // ----------------------------------------
   // Hysteresis margins
   // ----------------------------------------
   reg [FW-1:0] fon_ff;
   reg [FW-1:0] foff_ff;

   // Margins track the maximum frequency setting every cycle
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         fon_ff <= `DSOL_RST_FREQ;
         foff_ff <= `DSOL_RST_FREQ;
      end else begin
         fon_ff <= pct(max_freq_ff, `DSOL_PCT_ON);
         foff_ff <= pct(max_freq_ff, `DSOL_PCT_OFF);
      end
   end

   // ----------------------------------------
   // Indicators
   // ----------------------------------------
   reg run_ind_ff;
   wire steady;
   wire const_speed_arrival;
   wire over_freq_arrival_a;
   wire over_freq_arrival_b;
   wire set_freq_arrival_a;
   wire set_freq_arrival_b;

   assign steady = I_RUN_MODE & ~I_RAMP_ACCEL & ~I_RAMP_DECEL;

   // Running indicator: run mode and above start frequency
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         run_ind_ff <= 1'b0;
      end else begin
         run_ind_ff <= I_RUN_MODE & (I_OUT_FREQ > start_freq_ff);
      end
   end

   // Constant speed: band around standard set frequency, off while ramping
   dsol_band #(.FW(FW)) u_const (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_en(steady),
      .i_freq(I_OUT_FREQ),
      .i_on_lo(sat_sub(standard_set_frequency_ff, fon_ff)),
      .i_on_hi(sat_add(standard_set_frequency_ff, fon_ff)),
      .i_off_lo(sat_sub(standard_set_frequency_ff, foff_ff)),
      .i_off_hi(sat_add(standard_set_frequency_ff, foff_ff)),
      .o_flag(const_speed_arrival)
   );

   // Over frequency and set frequency pairs, one per threshold pair
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pair
         wire [FW-1:0] acc_thr;
         wire [FW-1:0] dec_thr;
         wire [FW-1:0] over_on_lo;
         wire [FW-1:0] over_off_lo;
         wire [FW-1:0] set_lo;
         wire [FW-1:0] set_hi;
         wire over_flag;
         wire set_flag;
         assign acc_thr = (g == 0) ? accel_on_threshold_a_ff : accel_on_threshold_b_ff;
         assign dec_thr = (g == 0) ? decel_off_threshold_a_ff : decel_off_threshold_b_ff;
         // Turn-on away from decel, or during decel only at full-scale frequency; turn-off only during decel
         assign over_on_lo = I_RAMP_DECEL ? FULL : sat_sub(acc_thr, fon_ff);
         assign over_off_lo = I_RAMP_DECEL ? sat_sub(dec_thr, foff_ff) : ZERO;
         // Accel band and decel band for set frequency arrival
         assign set_lo = I_RAMP_DECEL ? sat_sub(dec_thr, foff_ff) : sat_sub(acc_thr, fon_ff);
         assign set_hi = I_RAMP_DECEL ? sat_add(dec_thr, fon_ff) : sat_add(acc_thr, foff_ff);

         dsol_band #(.FW(FW)) u_over (
            .i_clk(I_CORE_CLK),
            .i_rst(I_SYS_RST),
            .i_en(I_RUN_MODE),
            .i_freq(I_OUT_FREQ),
            .i_on_lo(over_on_lo),
            .i_on_hi(FULL),
            .i_off_lo(over_off_lo),
            .i_off_hi(FULL),
            .o_flag(over_flag)
         );

         dsol_band #(.FW(FW)) u_set (
            .i_clk(I_CORE_CLK),
            .i_rst(I_SYS_RST),
            .i_en(I_RUN_MODE),
            .i_freq(I_OUT_FREQ),
            .i_on_lo(set_lo),
            .i_on_hi(set_hi),
            .i_off_lo(set_lo),
            .i_off_hi(set_hi),
            .o_flag(set_flag)
         );
      end
   endgenerate

   assign over_freq_arrival_a = g_pair[0].over_flag;
   assign over_freq_arrival_b = g_pair[1].over_flag;
   assign set_freq_arrival_a = g_pair[0].set_flag;
   assign set_freq_arrival_b = g_pair[1].set_flag;

   // ----------------------------------------
   // Terminal function select and drive
   // ----------------------------------------
   reg [NTERM-1:0] term_oe_ff;
   reg [NTERM-1:0] term_out_n_ff;
   reg [NTERM-1:0] nxt_term_act;
   integer t;

   // Each terminal picks its own function independently
   always @* begin
      nxt_term_act = {NTERM{1'b0}};
      for (t = 0; t < NTERM; t = t + 1) begin
         case (func_sel_ff[t*8 +: 8])
            `DSOL_CODE_RUN: nxt_term_act[t] = run_ind_ff;
            `DSOL_CODE_CONST_SPEED: nxt_term_act[t] = const_speed_arrival;
            `DSOL_CODE_OVER_A: nxt_term_act[t] = over_freq_arrival_a;
            `DSOL_CODE_SET_A: nxt_term_act[t] = set_freq_arrival_a;
            `DSOL_CODE_OVER_B: nxt_term_act[t] = over_freq_arrival_b;
            `DSOL_CODE_SET_B: nxt_term_act[t] = set_freq_arrival_b;
            default: nxt_term_act[t] = 1'b0;
         endcase
      end
   end

   // Active terminal pulls low with enable set, idle terminal released
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         term_oe_ff <= {NTERM{1'b0}};
         term_out_n_ff <= {NTERM{1'b1}};
      end else begin
         term_oe_ff <= nxt_term_act;
         term_out_n_ff <= ~nxt_term_act;
      end
   end

   assign O_TERM_OE = term_oe_ff;
   assign O_TERM_OUT_N = term_out_n_ff;

   // Status word: indicators and terminal activity
   always @* begin
      status_word = 32'h0000_0000;
      status_word[`DSOL_ST_RUN] = run_ind_ff;
      status_word[`DSOL_ST_CONST] = const_speed_arrival;
      status_word[`DSOL_ST_OVER_A] = over_freq_arrival_a;
      status_word[`DSOL_ST_SET_A] = set_freq_arrival_a;
      status_word[`DSOL_ST_OVER_B] = over_freq_arrival_b;
      status_word[`DSOL_ST_SET_B] = set_freq_arrival_b;
      status_word[`DSOL_ST_TERM_LSB +: NTERM] = term_oe_ff;
   end

endmodule // dsol_top

`default_nettype wire

//--- dsol_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dsol_checker #(
   parameter FW = 16,
   parameter NTERM = 3
) (
   input wire I_CORE_CLK,
   input wire I_SYS_RST,
   input wire [5:0] I_AVS_ADDRESS,
   input wire I_AVS_READ,
   input wire I_AVS_WRITE,
   input wire [31:0] I_AVS_WRITEDATA,
   input wire [3:0] I_AVS_BYTEENABLE,
   input wire [31:0] O_AVS_READDATA,
   input wire O_AVS_WAITREQUEST,
   input wire I_RUN_MODE,
   input wire I_RAMP_ACCEL,
   input wire I_RAMP_DECEL,
   input wire [FW-1:0] I_OUT_FREQ,
   input wire [NTERM-1:0] O_TERM_OUT_N,
   input wire [NTERM-1:0] O_TERM_OE
);
   // ----------------------------------------
   // Shadow of terminal 0 code and start frequency
   // ----------------------------------------
   logic [7:0] code0_ff;
   logic [FW-1:0] start_ff;
   logic run_ff;
   wire wr_done = I_AVS_WRITE && !O_AVS_WAITREQUEST;
   // Follows completed writes and the run condition
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         code0_ff <= 8'h00;
         start_ff <= '0;
         run_ff <= 1'b0;
      end else begin
         if (wr_done && I_AVS_ADDRESS[5:2] == 4'h7 && I_AVS_BYTEENABLE[0])
            code0_ff <= I_AVS_WRITEDATA[7:0];
         if (wr_done && I_AVS_ADDRESS[5:2] == 4'h1 && I_AVS_BYTEENABLE[1:0] == 2'h3)
            start_ff <= I_AVS_WRITEDATA[FW-1:0];
         run_ff <= I_RUN_MODE && (I_OUT_FREQ > start_ff);
      end
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_oe_inverse: assert property (O_TERM_OE == ~O_TERM_OUT_N)
      else $error("terminal enable and level disagree");
   chk_wait_answer: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
      else $error("access not answered after one wait cycle");
   chk_wait_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("waitrequest low longer than one cycle");
   chk_wait_idle: assert property (!I_AVS_READ && !I_AVS_WRITE && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("waitrequest dropped without a request");
   chk_rdata_hold: assert property (!(I_AVS_READ && O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA))
      else $error("read data changed without a read");
   chk_unmapped_rd: assert property (I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS > 6'h23
      |=> O_AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   chk_start_rd: assert property (I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS[5:2] == 4'h1
      |=> O_AVS_READDATA[FW-1:0] == $past(start_ff))
      else $error("start frequency readback wrong");
   chk_run_term: assert property ($past(code0_ff) == 8'h00 |-> O_TERM_OE[0] == $past(run_ff))
      else $error("run terminal does not follow run condition");
   chk_bad_code: assert property (!($past(code0_ff) inside {8'h00, 8'h01, 8'h02, 8'h06, 8'h24, 8'h25})
      |-> !O_TERM_OE[0])
      else $error("unknown code drives terminal");
   chk_reset_idle: assert property ($fell(I_SYS_RST) |-> O_TERM_OE == '0 && O_AVS_WAITREQUEST)
      else $error("outputs not idle after reset");
endmodule // dsol_checker

bind dsol_top dsol_checker #(.FW(FW), .NTERM(NTERM)) chk_u (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
   .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
   .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_RUN_MODE(I_RUN_MODE), .I_RAMP_ACCEL(I_RAMP_ACCEL),
   .I_RAMP_DECEL(I_RAMP_DECEL), .I_OUT_FREQ(I_OUT_FREQ), .O_TERM_OUT_N(O_TERM_OUT_N), .O_TERM_OE(O_TERM_OE));
`default_nettype wire

//--- dsol_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsol_relay_model #(
   parameter NTERM = 3
) (
   input wire logic [NTERM-1:0] i_term_n,
   input wire logic [NTERM-1:0] i_term_oe,
   output wire logic [NTERM-1:0] o_relay_on
);
   // Pull-up holds a released line high; the coil pulls in when the line is low
   wire logic [NTERM-1:0] line_lvl = i_term_n | ~i_term_oe;
   assign o_relay_on = ~line_lvl;
endmodule // dsol_relay_model
`default_nettype wire

//--- tb_drive_status_output_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_drive_status_output_logic;
   localparam logic [15:0] MAXF = 16'h2710;
   localparam logic [15:0] FON = MAXF / 16'h0064;
   localparam logic [15:0] FOFF = MAXF * 16'h0002 / 16'h0064;
   localparam logic [15:0] STD = 16'h0bb8;
   localparam logic [15:0] ACCA = 16'h1388;
   localparam logic [15:0] DECA = 16'h0fa0;
   localparam logic [15:0] THRB = 16'h1770;
   localparam logic [15:0] STARTF = 16'h0032;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] addr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic run = 1'b0;
   logic acc = 1'b0;
   logic dec = 1'b0;
   logic [15:0] freq = 16'h0;
   wire [31:0] rdata;
   wire waitreq;
   wire [2:0] term_n;
   wire [2:0] term_oe;
   wire [2:0] relay_on;
   integer mismatches = 0;
   integer total_checks = 0;
   integer i;
   integer p;
   logic [31:0] seed = 32'h00000022;
   logic [23:0] codes;
   logic [24:0] tbl [0:19];
   logic [31:0] q_exp [$];
   logic [31:0] q_msk [$];
   logic [3:0] q_term [$];

   always #5 clk = ~clk;

   dsol_top #(.FW(16), .NTERM(3)) dut_u (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_RUN_MODE(run), .I_RAMP_ACCEL(acc),
      .I_RAMP_DECEL(dec), .I_OUT_FREQ(freq), .O_TERM_OUT_N(term_n), .O_TERM_OE(term_oe));
   dsol_relay_model #(.NTERM(3)) relay_u (.i_term_n(term_n), .i_term_oe(term_oe), .o_relay_on(relay_on));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   // Terminal level chosen by its function code
   function automatic logic tsel(input logic [7:0] c, input logic [5:0] fl);
      case (c)
         8'h00: return fl[0];
         8'h01: return fl[1];
         8'h02: return fl[2];
         8'h06: return fl[3];
         8'h24: return fl[4];
         8'h25: return fl[5];
         default: return 1'b0;
      endcase
   endfunction

   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task compare_rd(input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t read exp %h got %h", $time, e, g);
      end
   endtask

   task compare_term(input logic [2:0] e, input logic [2:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t relay exp %h got %h", $time, e, g);
      end
   endtask

   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   task bus_wait;
      integer n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         mismatches++;
         print_verdict;
      end
   endtask

   task bus_write(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      bus_wait;
      wr <= 1'b0;
   endtask

   task bus_read(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m, input logic [3:0] t);
      q_exp.push_back(e & m);
      q_msk.push_back(m);
      q_term.push_back(t);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      bus_wait;
      rd <= 1'b0;
   endtask

   // Drive the drive state, let it settle, then read status and relays
   task step(input logic [24:0] s);
      logic [2:0] t;
      integer k;
      for (k = 0; k < 3; k++) t[k] = tsel(codes[8*k+:8], s[5:0]);
      @(posedge clk);
      run <= s[24];
      acc <= s[23];
      dec <= s[22];
      freq <= s[21:6];
      repeat (3) @(posedge clk);
      bus_read(6'h20, {21'h0, t, 2'h0, s[5:0]}, 32'h0000073f, {1'b1, t});
   endtask

   // ----------------------------------------
   // Monitor: oldest note against each completed read
   // ----------------------------------------
   always @(posedge clk) begin
      if (rd && waitreq === 1'b0 && q_exp.size() > 0) begin
         compare_rd(q_exp[0], rdata & q_msk[0]);
         if (q_term[0][3]) compare_term(q_term[0][2:0], relay_on);
         void'(q_exp.pop_front());
         void'(q_msk.pop_front());
         void'(q_term.pop_front());
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      tbl = '{{3'b000, 16'h03e8, 6'h00}, {3'b110, STARTF, 6'h00},
         {3'b110, STARTF + 16'h0001, 6'h01}, {3'b110, STD - FON - 16'h0001, 6'h01},
         {3'b100, STD - FON, 6'h03}, {3'b100, STD + FOFF, 6'h03},
         {3'b100, STD + FOFF + 16'h0001, 6'h01}, {3'b100, STD + FON + 16'h0032, 6'h01},
         {3'b110, ACCA - FON - 16'h0001, 6'h01}, {3'b110, ACCA - FON, 6'h0d},
         {3'b110, ACCA + FOFF, 6'h0d}, {3'b110, ACCA + FOFF + 16'h0001, 6'h05},
         {3'b110, THRB - FON, 6'h35}, {3'b110, THRB + FOFF + FON, 6'h15},
         {3'b101, THRB + FON, 6'h35}, {3'b101, THRB - FOFF - 16'h0001, 6'h05},
         {3'b101, DECA + FON, 6'h0d}, {3'b101, DECA - FOFF - 16'h0001, 6'h01},
         {3'b000, STD, 6'h00}, {3'b100, STD, 6'h03}};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 10; i++) bus_read(6'(i * 4), (i == 7) ? 32'h00000100 : 32'h0, 32'hffffffff, 4'h0);
      $display("test reset_values done");
      for (i = 0; i < 7; i++) begin
         seed = xorshift(seed);
         bus_write(6'(i * 4), {16'h0, seed[15:0]});
         bus_read(6'(i * 4), {16'h0, seed[15:0]}, 32'h0000ffff, 4'h0);
      end
      bus_write(6'h20, 32'hffffffff);
      bus_write(6'h24, 32'hffffffff);
      bus_read(6'h24, 32'h0, 32'hffffffff, 4'h0);
      $display("test readback done");
      for (p = 0; p < 3; p++) begin
         codes = (p == 0) ? 24'h020100 : (p == 1) ? 24'h252406 : 24'h7f7f7f;
         bus_write(6'h00, {16'h0, MAXF});
         bus_write(6'h04, {16'h0, STARTF});
         bus_write(6'h08, {16'h0, STD});
         bus_write(6'h0c, {16'h0, ACCA});
         bus_write(6'h10, {16'h0, DECA});
         bus_write(6'h14, {16'h0, THRB});
         bus_write(6'h18, {16'h0, THRB});
         bus_write(6'h1c, {8'h0, codes});
         for (i = 0; i < 20; i++) step(tbl[i]);
         $display("test profile %0d done", p);
      end
      bus_write(6'h00, {16'h0, MAXF * 16'h0002});
      step({3'b100, 16'h0000, 6'h00});
      step({3'b100, STD - FON - FON, 6'h03});
      $display("test margin_update done");
      print_verdict;
   end
endmodule // tb_drive_status_output_logic
`default_nettype wire
